// ===== logic/ccg_consts.vh
// Offsets, field positions, reset values and timing constants of the clock generator
`ifndef CCG_CONSTS_VH
`define CCG_CONSTS_VH
`define CCG_OFS_PCC       4'h0
`define CCG_OFS_PSC       4'h1
`define CCG_OFS_STABILIZATION_TIME_SELECT      4'h2
`define CCG_OFS_PROTECT   4'h3
`define CCG_OFS_STATUS    4'h4
`define CCG_OFS_PCC_BIT   4'h5
`define CCG_PCC_RESET     8'h03
`define CCG_PSC_RESET     8'hC0
`define CCG_STABILIZATION_TIME_SELECT_RESET    3'h4
`define CCG_PROTECT_KEY   8'hA5
`define CCG_PCC_FRC_BIT   7
`define CCG_PCC_MCK_BIT   6
`define CCG_PCC_CK2_BIT   2
`define CCG_PCC_WMASK     8'hC7
`define CCG_PSC_DCLK_HI   7
`define CCG_PSC_DCLK_LO   6
`define CCG_PSC_IDLE_BIT  1
`define CCG_PSC_STP_BIT   0
`define CCG_PSC_WMASK     8'hC3
`define CCG_BIT_VAL_POS   8
`define CCG_RESP_OKAY     2'h0
`define CCG_RESP_SLVERR   2'h2
`define CCG_STAB_EXP0     5'h0E
`define CCG_STAB_EXP1     5'h10
`define CCG_STAB_EXP2     5'h11
`define CCG_STAB_EXP3     5'h12
`define CCG_STAB_EXP4     5'h13
`endif

// ===== logic/ccg_stab_timer.v
// Oscillation stabilization wait counter
`timescale 1ns/1ps
`include "ccg_consts.vh"
module ccg_stab_timer #(
    parameter SCALE_SHIFT = 0
) (
    // Clock, reset and enable
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       ce,
    // Control
    input  wire       start,
    input  wire [2:0] sel,
    // Status
    output reg        busy_q
);
    reg  [19:0] cnt_q;
    reg  [4:0]  exp_w;
    wire [19:0] load_w;

    always @* begin
        case (sel)
            3'h0:    exp_w = `CCG_STAB_EXP0;
            3'h1:    exp_w = `CCG_STAB_EXP1;
            3'h2:    exp_w = `CCG_STAB_EXP2;
            3'h3:    exp_w = `CCG_STAB_EXP3;
            default: exp_w = `CCG_STAB_EXP4;
        endcase
    end

    assign load_w = ((20'h00001 << exp_w) >> SCALE_SHIFT) - 20'h00001;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= 20'h00000;
            busy_q <= 1'b0;
        end else if (ce) begin
            if (start) begin
                cnt_q  <= load_w;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q == 20'h00000)
                    busy_q <= 1'b0;
                else
                    cnt_q <= cnt_q - 20'h00001;
            end
        end
    end
endmodule // ccg_stab_timer

// ===== logic/ccg_top.v
// CPU clock generator with protected control registers on AXI4-Lite
//
// Summary of operation
// [R1] Select 000..011 gives main clock divided by 1,2,4,8; top bit picks subclock.
// [R2] Main-clock stop bit 0 keeps oscillator running, 1 requests stop.
// [R3] Feedback-resistor bit 0 enables subclock resistor, 1 disables it.
// [R4] Main oscillator stops in reset, STOP, or via control register.
// [R5] After reset or STOP, a selectable stabilization wait runs before resuming.
// [R6] Restarting main oscillator by clearing stop bit inserts no wait.
// [R7] Subclock keeps running through STOP and reset.
// [R8] Stop bit only stops main oscillator once subclock is the CPU clock.
// [R9] In IDLE a clock can still reach the clock timer alone.
// [R10] Clock output enabled carries CPU clock; disabled drives low.
// [R11] In IDLE or STOP the clock output is fixed low.
// [R12] Clock output is high-impedance in reset, low after release.
// [R13] Software must not change clock select while clock output is enabled.
// [R14] Control registers take writes only after the protection sequence; the stabilization select register takes writes without it.
// [R15] Clock control register allows whole-byte and single-bit access.
// [R16] Software changes subclock select by bit access, keeping divider bits.
// [R17] Software must not enter HALT or STOP on the subclock.
// [R18] Software writes zero to clock control bits 3 to 5.
// [R19] Clock output control 00 enables, 11 disables, 11 after reset.
// [R20] Stabilization code 000..100 picks 2^14,16,17,18,19 periods; reset 100.
// [R21] Source and divider switch only at period ends, without short pulses.
`timescale 1ns/1ps
`include "ccg_consts.vh"
module ccg_top #(
    parameter STAB_SCALE_SHIFT = 0
) (
    // Clock, reset, enable
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    input  wire [31:0] s_axi_awaddr,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg         s_axi_bvalid,
    output reg  [1:0]  s_axi_bresp,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    input  wire [31:0] s_axi_araddr,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg         s_axi_rvalid,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    input  wire        s_axi_rready,
    // Power-mode events
    input  wire        stop_instr,
    input  wire        wake_event,
    input  wire        idle_timer_keep,
    // Subclock sampled as a level
    input  wire        subclock_in,
    // Clock and oscillator controls
    output reg         main_osc_en_q,
    output reg         sub_osc_en_q,
    output reg         feedback_resistor_off_q,
    output reg         cpu_clk_en_q,
    output reg         periph_clk_en_q,
    output reg         timer_clk_en_q,
    output reg         stab_busy_q,
    // Clock output pin
    output reg         cpu_clock_out_pin_o_q,
    output reg         cpu_clock_out_pin_oe_q
);
    reg  [7:0]  processor_clock_control_q;
    reg  [7:0]  power_save_control_q;
    reg  [2:0]  stabilization_time_select_q;
    reg         armed_q;
    reg  [2:0]  applied_sel_q;
    reg  [2:0]  div_cnt_q;
    reg         sub_prev_q;
    reg         boot_q;
    reg         aw_held_q;
    reg  [3:0]  aw_idx_q;
    reg         w_held_q;
    reg  [31:0] w_data_q;
    reg         w_lane0_q;
    reg  [2:0]  div_mask_w;
    reg  [31:0] rd_w;
    reg         rd_ok_w;
    wire        stab_busy_w;
    wire        sub_rise_w;
    wire        main_tick_w;
    wire        src_end_w;
    wire        cpu_tick_w;
    wire        idle_w;
    wire        stop_w;
    wire        do_wr_w;
    wire        wr_ok_w;
    wire        prot_ok_w;
    wire        stab_start_w;
    wire        cpu_clock_out_pin_on_w;
    wire [3:0]  ar_idx_w;
    wire [2:0]  bit_idx_w;

    localparam [7:0] PCC_RESET_V = `CCG_PCC_RESET;

    assign idle_w = power_save_control_q[`CCG_PSC_IDLE_BIT];
    assign stop_w = power_save_control_q[`CCG_PSC_STP_BIT];
    assign sub_rise_w = subclock_in & ~sub_prev_q;
    assign main_tick_w = main_osc_en_q & ~stab_busy_w;

    // Divider mask for the applied select
    always @* begin
        case (applied_sel_q[1:0])
            2'h0:    div_mask_w = 3'h0;
            2'h1:    div_mask_w = 3'h1;
            2'h2:    div_mask_w = 3'h3;
            default: div_mask_w = 3'h7;
        endcase
    end

    // End of a current CPU period
    assign src_end_w = applied_sel_q[2] ? sub_rise_w              // see [R1]
                     : (main_tick_w & (div_cnt_q == div_mask_w));
    assign cpu_tick_w = src_end_w;

    // Wake from STOP, or first cycle after reset, starts the wait
    assign stab_start_w = boot_q | (wake_event & stop_w);           // see [R5]

    ccg_stab_timer #(
        .SCALE_SHIFT (STAB_SCALE_SHIFT)
    ) u_stab (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .start   (stab_start_w),
        .sel     (stabilization_time_select_q),                     // see [R20]
        .busy_q  (stab_busy_w)
    );

    // AXI4-Lite write path
    assign do_wr_w = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign wr_ok_w = (aw_idx_q <= `CCG_OFS_PCC_BIT)
                   && (aw_idx_q != `CCG_OFS_STATUS);
    assign prot_ok_w = armed_q & w_lane0_q;                         // see [R14]
    assign bit_idx_w = w_data_q[2:0];
    assign ar_idx_w = s_axi_araddr[5:2];

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CCG_RESP_OKAY;
            aw_held_q     <= 1'b0;
            aw_idx_q      <= 4'h0;
            w_held_q      <= 1'b0;
            w_data_q      <= 32'h00000000;
            w_lane0_q     <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q     <= 1'b1;
                aw_idx_q      <= (s_axi_awaddr[31:6] == 26'h0)
                                 ? s_axi_awaddr[5:2] : 4'hF;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_lane0_q    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_wr_w) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok_w ? `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Control registers, protection and power modes
    always @(posedge aclk) begin
        if (!aresetn) begin
            processor_clock_control_q   <= `CCG_PCC_RESET;
            power_save_control_q        <= `CCG_PSC_RESET;          // see [R19]
            stabilization_time_select_q <= `CCG_STABILIZATION_TIME_SELECT_RESET;         // see [R20]
            armed_q                     <= 1'b0;
        end else if (ce) begin
            if (do_wr_w)
                armed_q <= (aw_idx_q == `CCG_OFS_PROTECT) && w_lane0_q
                           && (w_data_q[7:0] == `CCG_PROTECT_KEY);  // see [R14]
            if (do_wr_w && aw_idx_q == `CCG_OFS_PCC && prot_ok_w)
                processor_clock_control_q <= w_data_q[7:0]
                                             & `CCG_PCC_WMASK;      // see [R15]
            if (do_wr_w && aw_idx_q == `CCG_OFS_PCC_BIT && prot_ok_w
                && ((`CCG_PCC_WMASK >> bit_idx_w) & 8'h01) != 8'h00)
                processor_clock_control_q[bit_idx_w] <=
                    w_data_q[`CCG_BIT_VAL_POS];                     // see [R15]
            if (do_wr_w && aw_idx_q == `CCG_OFS_STABILIZATION_TIME_SELECT && w_lane0_q)
                stabilization_time_select_q <= w_data_q[2:0];
            if (do_wr_w && aw_idx_q == `CCG_OFS_PSC && prot_ok_w)
                power_save_control_q <= w_data_q[7:0] & `CCG_PSC_WMASK;
            // Wake clears mode bits; a STOP instruction sets it and wins
            if (wake_event) begin
                power_save_control_q[`CCG_PSC_IDLE_BIT] <= 1'b0;
                power_save_control_q[`CCG_PSC_STP_BIT]  <= 1'b0;
            end
            if (stop_instr)
                power_save_control_q[`CCG_PSC_STP_BIT] <= 1'b1;     // see [R4]
        end
    end

    // Read mux
    always @* begin
        rd_w = 32'h00000000;
        rd_ok_w = 1'b1;
        if (s_axi_araddr[31:6] != 26'h0)
            rd_ok_w = 1'b0;
        else begin
            case (ar_idx_w)
                `CCG_OFS_PCC:     rd_w[7:0] = processor_clock_control_q;
                `CCG_OFS_PSC:     rd_w[7:0] = power_save_control_q;
                `CCG_OFS_STABILIZATION_TIME_SELECT:    rd_w[2:0] = stabilization_time_select_q;
                `CCG_OFS_PROTECT: rd_w[0]   = armed_q;
                `CCG_OFS_STATUS:  rd_w[5:0] = {stab_busy_w, main_osc_en_q,
                                               armed_q, applied_sel_q};
                `CCG_OFS_PCC_BIT: rd_w[7:0] = processor_clock_control_q;
                default:          rd_ok_w   = 1'b0;
            endcase
        end
    end

    // AXI4-Lite read path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CCG_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_w;
                s_axi_rresp   <= rd_ok_w ? `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    assign cpu_clock_out_pin_on_w = (power_save_control_q[`CCG_PSC_DCLK_HI:
                          `CCG_PSC_DCLK_LO] == 2'h0)                // see [R19]
                         & ~idle_w & ~stop_w;                       // see [R11]

    // Clock selection, dividers and oscillator controls
    always @(posedge aclk) begin
        if (!aresetn) begin
            applied_sel_q           <= PCC_RESET_V[2:0];
            div_cnt_q               <= 3'h0;
            sub_prev_q              <= 1'b0;
            boot_q                  <= 1'b1;
            main_osc_en_q           <= 1'b0;                        // see [R4]
            sub_osc_en_q            <= 1'b1;                        // see [R7]
            feedback_resistor_off_q <= 1'b0;
            cpu_clk_en_q            <= 1'b0;
            periph_clk_en_q         <= 1'b0;
            timer_clk_en_q          <= 1'b0;
            stab_busy_q             <= 1'b0;
            cpu_clock_out_pin_o_q   <= 1'b0;
            cpu_clock_out_pin_oe_q  <= 1'b0;                        // see [R12]
        end else if (ce) begin
            boot_q        <= 1'b0;
            sub_prev_q    <= subclock_in;
            sub_osc_en_q  <= 1'b1;                                  // see [R7]
            stab_busy_q   <= stab_busy_w;
            feedback_resistor_off_q <=
                processor_clock_control_q[`CCG_PCC_FRC_BIT];        // see [R3]
            // Stop bit acts only while the subclock drives the CPU
            main_osc_en_q <= ~stop_w                 // see [R4] [R6]
                & ~(processor_clock_control_q[`CCG_PCC_MCK_BIT]     // see [R2]
                    & applied_sel_q[2]);                            // see [R8]
            // Divider restarts at every period end; select changes there
            if (src_end_w) begin
                div_cnt_q     <= 3'h0;
                applied_sel_q <= processor_clock_control_q[2:0];    // see [R21]
            end else if (main_tick_w)
                div_cnt_q <= div_cnt_q + 3'h1;
            cpu_clk_en_q    <= cpu_tick_w & ~idle_w & ~stop_w;
            periph_clk_en_q <= main_tick_w & ~idle_w & ~stop_w;
            timer_clk_en_q  <= main_tick_w & ~stop_w
                               & (~idle_w | idle_timer_keep);       // see [R9]
            cpu_clock_out_pin_oe_q <= 1'b1;                         // see [R12]
            if (!cpu_clock_out_pin_on_w)
                cpu_clock_out_pin_o_q <= 1'b0;                      // see [R10]
            else if (cpu_tick_w)
                cpu_clock_out_pin_o_q <= ~cpu_clock_out_pin_o_q;    // see [R10]
        end
    end
endmodule // ccg_top

// ===== verif/ccg_checker.sv
// Port-level assertions for the clock generator
`timescale 1ns/1ps
module ccg_checker (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Bus handshakes
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_awready,
    // Clock controls
    input logic main_osc_en_q,
    input logic sub_osc_en_q,
    input logic cpu_clk_en_q,
    input logic periph_clk_en_q,
    input logic stab_busy_q,
    input logic cpu_clock_out_pin_o_q,
    input logic cpu_clock_out_pin_oe_q
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_busy2;
        stab_busy_q ##1 stab_busy_q;
    endsequence
    sequence s_main_off2;
        !main_osc_en_q ##1 !main_osc_en_q;
    endsequence
    sequence s_oe_release;
        !cpu_clock_out_pin_oe_q ##1 cpu_clock_out_pin_oe_q;
    endsequence

    a_oe_release: assert property ($rose(aresetn) |-> s_oe_release)
        else $error("pin enable wrong around reset release");
    a_sub_runs: assert property (sub_osc_en_q)
        else $error("subclock oscillator stopped");
    a_pin_on_tick: assert property ($rose(cpu_clock_out_pin_o_q) |->
        cpu_clk_en_q || $past(cpu_clk_en_q))
        else $error("clock pin rose without a cpu tick");
    a_no_tick_busy: assert property (s_busy2 |-> !cpu_clk_en_q)
        else $error("cpu tick during stabilization wait");
    a_main_off_quiet: assert property (s_main_off2 |->
        !periph_clk_en_q)
        else $error("peripheral tick with main oscillator stopped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready)
        else $error("write not closed");
endmodule // ccg_checker

bind ccg_top ccg_checker u_chk (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_awready(s_axi_awready), .main_osc_en_q(main_osc_en_q),
    .sub_osc_en_q(sub_osc_en_q), .cpu_clk_en_q(cpu_clk_en_q),
    .periph_clk_en_q(periph_clk_en_q), .stab_busy_q(stab_busy_q),
    .cpu_clock_out_pin_o_q(cpu_clock_out_pin_o_q),
    .cpu_clock_out_pin_oe_q(cpu_clock_out_pin_oe_q)
);

// ===== verif/ccg_top_tb.sv
// Self-checking testbench for the clock generator
`timescale 1ns/1ps
module ccg_top_tb;
    typedef struct {
        bit          w;
        logic [7:0]  a;
        logic [15:0] d;
        logic [7:0]  e;
        logic [1:0]  r;
    } ccg_row_t;
    logic        aclk = '0, aresetn = '0, ce = 1'h1, subclock_in = '0;
    logic        stop_instr = '0, wake_event = '0, idle_timer_keep = '0;
    logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic        s_axi_arvalid = '0, s_axi_rready = '0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, main_osc_en_q, sub_osc_en_q, stab_busy_q;
    logic        feedback_resistor_off_q, cpu_clk_en_q, periph_clk_en_q;
    logic        timer_clk_en_q, cpu_clock_out_pin_o_q, cpu_clock_out_pin_oe_q;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    int          mismatches = 0, n_checks = 0, sc = 0, i;
    int          cn[5], c0[5];
    ccg_row_t    tab[14] = '{
        '{0, 8'h00, 16'h0, 8'h03, 2'h0},
        '{0, 8'h04, 16'h0, 8'hC0, 2'h0},
        '{0, 8'h08, 16'h0, 8'h04, 2'h0},
        '{0, 8'h10, 16'h0, 8'h13, 2'h0},
        '{0, 8'h40, 16'h0, 8'h00, 2'h2},
        '{1, 8'h40, 16'h0, 8'h00, 2'h2},
        '{1, 8'h00, 16'h0, 8'h00, 2'h0},
        '{0, 8'h00, 16'h0, 8'h03, 2'h0},
        '{1, 8'h10, 16'h0, 8'h00, 2'h2},
        '{1, 8'h08, 16'h0, 8'h00, 2'h0},
        '{0, 8'h08, 16'h0, 8'h00, 2'h0},
        '{1, 8'h0C, 16'hA5, 8'h00, 2'h0},
        '{1, 8'h00, 16'h01, 8'h00, 2'h0},
        '{0, 8'h00, 16'h0, 8'h01, 2'h0}
    };

    ccg_top #(.STAB_SCALE_SHIFT(12)) dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_araddr(s_axi_araddr),
        .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rready(s_axi_rready), .stop_instr(stop_instr),
        .wake_event(wake_event), .idle_timer_keep(idle_timer_keep),
        .subclock_in(subclock_in), .main_osc_en_q(main_osc_en_q),
        .sub_osc_en_q(sub_osc_en_q),
        .feedback_resistor_off_q(feedback_resistor_off_q),
        .cpu_clk_en_q(cpu_clk_en_q), .periph_clk_en_q(periph_clk_en_q),
        .timer_clk_en_q(timer_clk_en_q), .stab_busy_q(stab_busy_q),
        .cpu_clock_out_pin_o_q(cpu_clock_out_pin_o_q),
        .cpu_clock_out_pin_oe_q(cpu_clock_out_pin_oe_q)
    );

    always #5 aclk = ~aclk;

    // Subclock level, period of 40 cycles
    always @(posedge aclk) begin
        sc <= (sc == 19) ? 0 : sc + 1;
        if (sc == 19) subclock_in <= ~subclock_in;
    end

    // Running totals of ticks, pin high time and wait time
    always @(posedge aclk) begin
        cn[0] <= cn[0] + cpu_clk_en_q;
        cn[1] <= cn[1] + periph_clk_en_q;
        cn[2] <= cn[2] + timer_clk_en_q;
        cn[3] <= cn[3] + cpu_clock_out_pin_o_q;
        cn[4] <= cn[4] + stab_busy_q;
    end

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tmo();
        mismatches++;
        $display("Error at %0t: got %h, expected %h", $time, 0, 1);
        final_report();
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int k;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        if (k == 64) tmo();
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rdt(input logic [31:0] a);
        int k;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        if (k == 64) tmo();
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask

    // Key write, then the protected write
    task automatic pw(input logic [31:0] a, input logic [31:0] d);
        wr(32'h0C, 32'hA5);
        wr(a, d);
    endtask

    task automatic win(input int n);
        c0 = cn;
        repeat (n) @(posedge aclk);
        foreach (c0[j]) c0[j] = cn[j] - c0[j];
    endtask

    // One-cycle pulse on the STOP instruction or the wake event
    task automatic pulse(input bit stp);
        if (stp) stop_instr <= 1'h1;
        else wake_event <= 1'h1;
        @(posedge aclk);
        stop_instr <= 1'h0;
        wake_event <= 1'h0;
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        chk(cpu_clock_out_pin_oe_q, 0);
        chk(main_osc_en_q, 0);
        aresetn <= 1'h1;
        win(300);
        chk(c0[4] inside {[128:129]}, 1);
        chk(cpu_clock_out_pin_oe_q, 1);
        $display("Test reset done");
        foreach (tab[j]) begin
            if (tab[j].w) wr(tab[j].a, tab[j].d);
            else rdt(tab[j].a);
            chk(rs, tab[j].r);
            if (!tab[j].w && tab[j].r == 2'h0) chk(rd, tab[j].e);
        end
        $display("Test registers done");
        for (i = 0; i < 4; i++) begin
            pw(32'h00, i);
            repeat (20) @(posedge aclk);
            win(64);
            chk(c0[0], 64 >> i);
        end
        $display("Test dividers done");
        pw(32'h00, 32'h43);
        repeat (20) @(posedge aclk);
        chk(main_osc_en_q, 1);
        pw(32'h14, 32'h102);
        repeat (100) @(posedge aclk);
        chk(main_osc_en_q, 0);
        win(400);
        chk(c0[0], 10);
        chk(c0[1], 0);
        pw(32'h14, 32'h006);
        repeat (4) @(posedge aclk);
        chk(main_osc_en_q, 1);
        chk(stab_busy_q, 0);
        pw(32'h14, 32'h107);
        repeat (3) @(posedge aclk);
        chk(feedback_resistor_off_q, 1);
        pw(32'h14, 32'h002);
        repeat (100) @(posedge aclk);
        rdt(32'h00);
        chk(rd, 32'h83);
        $display("Test subclock done");
        // Select stays fixed while the pin is enabled
        pw(32'h04, 32'h00);
        repeat (20) @(posedge aclk);
        win(160);
        chk(c0[3], 80);
        $display("Test clock out done");
        pulse(1'b1);
        repeat (10) @(posedge aclk);
        win(20);
        chk(c0[3], 0);
        chk(main_osc_en_q, 0);
        chk(sub_osc_en_q, 1);
        pulse(1'b0);
        win(40);
        chk(c0[4] inside {[4:5]}, 1);
        chk(main_osc_en_q, 1);
        $display("Test stop done");
        pw(32'h04, 32'h02);
        idle_timer_keep <= 1'h1;
        repeat (5) @(posedge aclk);
        win(20);
        chk(c0[1], 0);
        chk(c0[2], 20);
        chk(c0[3], 0);
        idle_timer_keep <= 1'h0;
        repeat (2) @(posedge aclk);
        win(20);
        chk(c0[2], 0);
        pulse(1'b0);
        pw(32'h04, 32'hC0);
        repeat (5) @(posedge aclk);
        win(32);
        chk(c0[3], 0);
        chk(c0[0], 4);
        $display("Test idle done");
        // Frozen block ignores a STOP instruction
        ce <= 1'h0;
        pulse(1'b1);
        repeat (3) @(posedge aclk);
        chk(main_osc_en_q, 1);
        ce <= 1'h1;
        repeat (3) @(posedge aclk);
        chk(main_osc_en_q, 1);
        $display("Test enable done");
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        chk(cpu_clock_out_pin_oe_q, 0);
        chk(main_osc_en_q, 0);
        chk(sub_osc_en_q, 1);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        chk(cpu_clock_out_pin_oe_q, 1);
        $display("Test second reset done");
        final_report();
    end
endmodule // ccg_top_tb
